/* File: bit_fifo.sv */
// Parameterised FIFO with registered read data
`timescale 1ns/10ps
`default_nettype none

module bit_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic out_valid;
        logic [WIDTH-1:0] out_data;
    } fifo_state_s;

    fifo_state_s state_ff;
    fifo_state_s nxt_state;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////////
    // Handshakes: full stalls the writer, empty holds the reader off
    assign in_ready = (state_ff.count != (AW+1)'(DEPTH));
    assign push = in_valid & in_ready;
    assign pop = (state_ff.count != '0) & (~state_ff.out_valid | out_ready);

    // Next state
    always_comb begin
        nxt_state = state_ff;
        if (out_ready) begin
            nxt_state.out_valid = 1'b0;
        end
        if (pop) begin
            nxt_state.out_data = state_ff.mem[state_ff.rd_ptr];
            nxt_state.out_valid = 1'b1;
            nxt_state.rd_ptr = state_ff.rd_ptr + 1'b1;
        end
        if (push) begin
            nxt_state.mem[state_ff.wr_ptr] = in_data;
            nxt_state.wr_ptr = state_ff.wr_ptr + 1'b1;
        end
        nxt_state.count = state_ff.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign out_valid = state_ff.out_valid;
    assign out_data = state_ff.out_data;

endmodule : bit_fifo

`default_nettype wire

/* File: cvsd_core.sv */
// Top of the slope delta digital core: sampling, history, coincidence, output FIFO
`timescale 1ns/10ps
`default_nettype none

module cvsd_core #(
    parameter logic [13:0] BIT_PERIOD_MAX = cvsd_pkg::BIT_PERIOD_MAX_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic bit_clk,
    input wire logic cmp_sign,
    input wire logic rx_bit,
    input wire logic dec_sel,
    input wire logic len4_strap,
    input wire logic out_ready,
    output logic dout,
    output logic slope_up,
    output logic coinc,
    output logic idle_alt,
    output logic rate_low,
    output logic out_valid,
    output logic [1:0] out_data
);

    typedef struct packed {
        logic bclk_s1;
        logic bclk_s2;
        logic bclk_d;
        logic sign_s1;
        logic sign_s2;
        logic rx_s1;
        logic rx_s2;
        logic dec_s1;
        logic dec_s2;
        logic len_s1;
        logic len_s2;
        logic len4;
        logic [1:0] strap_cnt;
        cvsd_pkg::run_state_e state;
        logic pend_bit;
        logic shift;
        logic push;
        logic dout;
        logic slope_up;
        logic coinc;
        logic idle_alt;
        logic [13:0] wd_cnt;
        logic rate_low;
    } core_state_s;

    core_state_s state_ff;
    core_state_s nxt_state;
    logic [1:0] rst_pipe_ff;
    logic rst_sync_n;
    logic bit_edge;
    logic new_bit;
    logic commit;
    logic [3:0] hist;
    logic hist_coinc;
    logic fifo_in_ready;
    logic [1:0] fifo_word;
    logic alt_now;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_ff <= 2'h0;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // Rising bit clock edge, seen only on the second sync stage
    assign bit_edge = state_ff.bclk_s2 & ~state_ff.bclk_d;

    // Bit source: comparator when encoding, line bits when decoding
    always_comb begin
        if (state_ff.dec_s2) begin
            new_bit = state_ff.rx_s2;
        end else begin
            new_bit = state_ff.sign_s2;
        end
    end

    // Idle pattern over the active history length
    always_comb begin
        if (state_ff.len4) begin
            alt_now = (hist == cvsd_pkg::ALT_A) | (hist == cvsd_pkg::ALT_B);
        end else begin
            alt_now = (hist[2:0] == cvsd_pkg::ALT3_A) | (hist[2:0] == cvsd_pkg::ALT3_B);
        end
    end

    // A bit is committed only once the previous word has been accepted
    always_comb begin
        commit = 1'b0;
        unique case (state_ff.state)
            cvsd_pkg::ST_STRAP: commit = 1'b0;
            cvsd_pkg::ST_RUN: commit = bit_edge & ~state_ff.push;
            cvsd_pkg::ST_HOLD: commit = ~state_ff.push;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the core
    always_comb begin
        nxt_state = state_ff;
        // Pin synchronisers
        nxt_state.bclk_s1 = bit_clk;
        nxt_state.bclk_s2 = state_ff.bclk_s1;
        nxt_state.bclk_d = state_ff.bclk_s2;
        nxt_state.sign_s1 = cmp_sign;
        nxt_state.sign_s2 = state_ff.sign_s1;
        nxt_state.rx_s1 = rx_bit;
        nxt_state.rx_s2 = state_ff.rx_s1;
        nxt_state.dec_s1 = dec_sel;
        nxt_state.dec_s2 = state_ff.dec_s1;
        nxt_state.len_s1 = len4_strap;
        nxt_state.len_s2 = state_ff.len_s1;
        nxt_state.shift = 1'b0;

        // Run state and stalling on a full FIFO
        unique case (state_ff.state)
            cvsd_pkg::ST_STRAP: begin
                // Strap sync stages still hold their reset value for two cycles
                nxt_state.len4 = state_ff.len_s2;
                nxt_state.strap_cnt = state_ff.strap_cnt + 2'h1;
                if (state_ff.strap_cnt == cvsd_pkg::STRAP_SETTLE) begin
                    nxt_state.state = cvsd_pkg::ST_RUN;
                end
            end
            cvsd_pkg::ST_RUN: begin
                if (bit_edge & state_ff.push) begin
                    nxt_state.pend_bit = new_bit;
                    nxt_state.state = cvsd_pkg::ST_HOLD;
                end
            end
            cvsd_pkg::ST_HOLD: begin
                if (commit) begin
                    nxt_state.state = cvsd_pkg::ST_RUN;
                end
            end
        endcase

        // One output bit per bit clock, same bit to line and slope switch
        if (commit) begin
            if (state_ff.state == cvsd_pkg::ST_HOLD) begin
                nxt_state.dout = state_ff.pend_bit;
                nxt_state.slope_up = state_ff.pend_bit;
            end else begin
                nxt_state.dout = new_bit;
                nxt_state.slope_up = new_bit;
            end
            nxt_state.shift = 1'b1;
        end

        // Word goes to the FIFO the cycle after the shift
        if (state_ff.shift) begin
            nxt_state.push = 1'b1;
        end else if (fifo_in_ready) begin
            nxt_state.push = 1'b0;
        end

        // Coincidence and idle follow the updated history
        nxt_state.coinc = hist_coinc;
        nxt_state.idle_alt = alt_now;

        // Bit clock slower than the least rate is flagged
        if (bit_edge) begin
            nxt_state.wd_cnt = 14'h0;
        end else if (state_ff.wd_cnt != BIT_PERIOD_MAX) begin
            nxt_state.wd_cnt = state_ff.wd_cnt + 14'h1;
        end
        nxt_state.rate_low = (state_ff.wd_cnt == BIT_PERIOD_MAX);
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_ff <= '0;
            state_ff.state <= cvsd_pkg::ST_STRAP;
            state_ff.idle_alt <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // History register and coincidence detector
    hist_shift u_hist (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .shift_en(state_ff.shift),
        .bit_in(state_ff.dout),
        .len4(state_ff.len4),
        .hist(hist),
        .coinc(hist_coinc)
    );

    // Output word: newest bit with its coincidence
    assign fifo_word[cvsd_pkg::FIFO_BIT_POS] = state_ff.dout;
    assign fifo_word[cvsd_pkg::FIFO_COINC_POS] = hist_coinc;

    bit_fifo #(
        .WIDTH(cvsd_pkg::FIFO_WIDTH),
        .DEPTH(cvsd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .in_valid(state_ff.push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_word),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign dout = state_ff.dout;
    assign slope_up = state_ff.slope_up;
    assign coinc = state_ff.coinc;
    assign idle_alt = state_ff.idle_alt;
    assign rate_low = state_ff.rate_low;

endmodule : cvsd_core

`default_nettype wire

/* File: cvsd_core_asserts.sv */
// Port-level checks of the slope delta core
`timescale 1ns/10ps
`default_nettype none

module cvsd_core_asserts #(
    parameter logic [13:0] BIT_PERIOD_MAX = 14'h0028
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic bit_clk,
    input wire logic cmp_sign,
    input wire logic rx_bit,
    input wire logic dec_sel,
    input wire logic len4_strap,
    input wire logic out_ready,
    input wire logic dout,
    input wire logic slope_up,
    input wire logic coinc,
    input wire logic idle_alt,
    input wire logic rate_low,
    input wire logic out_valid,
    input wire logic [1:0] out_data
);
    int cnt_ff;
    int bal_ff;
    logic bclk_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since the last bit edge, and bits not yet read out
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 0;
            bal_ff <= 0;
            bclk_ff <= 1'b0;
        end else begin
            bclk_ff <= bit_clk;
            bal_ff <= bal_ff + int'(bit_clk && !bclk_ff) - int'(out_valid && out_ready);
            if (bit_clk && !bclk_ff) begin
                cnt_ff <= 0;
            end else if (cnt_ff < int'(BIT_PERIOD_MAX) + 9) begin
                cnt_ff <= cnt_ff + 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Properties
    sequence s_bit_seen;
        $rose(bit_clk) && bal_ff < 10;
    endsequence
    property p_slope; slope_up == dout; endproperty
    property p_enc_src; s_bit_seen ##0 !dec_sel |-> ##6 (dout == $past(cmp_sign, 4)); endproperty
    property p_dec_src; s_bit_seen ##0 dec_sel |-> ##6 (dout == $past(rx_bit, 4)); endproperty
    property p_one_bit; $changed(dout) |=> $stable(dout)[*3]; endproperty
    property p_excl; !(coinc && idle_alt); endproperty
    property p_rst_idle; $rose(rst_n) |-> (idle_alt && !coinc && !out_valid)[*5]; endproperty
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
    property p_no_extra; out_valid |-> bal_ff > 0; endproperty
    property p_rate; cnt_ff == int'(BIT_PERIOD_MAX) + 8 |-> rate_low; endproperty

    a_slope: assert property (p_slope) else $error("slope select differs from bit");
    a_enc_src: assert property (p_enc_src) else $error("output bit not comparator sign");
    a_dec_src: assert property (p_dec_src) else $error("output bit not line bit");
    a_one_bit: assert property (p_one_bit) else $error("output bit changed twice");
    a_excl: assert property (p_excl) else $error("coincidence during alternation");
    a_rst_idle: assert property (p_rst_idle) else $error("wrong state after reset");
    a_hold: assert property (p_hold) else $error("stalled word not held");
    a_no_extra: assert property (p_no_extra) else $error("word without a bit");
    a_rate: assert property (p_rate) else $error("slow bit clock not flagged");
endmodule : cvsd_core_asserts

bind cvsd_core cvsd_core_asserts #(.BIT_PERIOD_MAX(BIT_PERIOD_MAX)) u_chk (.clk_sys, .rst_n,
    .bit_clk, .cmp_sign, .rx_bit, .dec_sel, .len4_strap, .out_ready, .dout, .slope_up, .coinc,
    .idle_alt, .rate_low, .out_valid, .out_data);

`default_nettype wire

/* File: cvsd_pkg.sv */
// Shared constants and types of the slope delta coincidence core
package cvsd_pkg;

    // History register lengths, chosen after reset from the len4_strap pin
    localparam int HIST_LEN_SHORT = 3;
    localparam int HIST_LEN_LONG = 4;
    localparam int HIST_W = 4;
    localparam logic [3:0] HIST_RST = 4'h5; // Idle alternation
    localparam logic [3:0] ALT_A = 4'h5;
    localparam logic [3:0] ALT_B = 4'ha;
    localparam logic [2:0] ALT3_A = 3'h5;
    localparam logic [2:0] ALT3_B = 3'h2;

    // Output FIFO shape: word is {coincidence, bit}
    localparam int FIFO_WIDTH = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_BIT_POS = 0;
    localparam int FIFO_COINC_POS = 1;

    // Timing
    localparam longint CLK_HZ = 100000000;
    localparam longint MIN_BIT_RATE_HZ = 8000;
    localparam int WD_W = 14;
    localparam logic [13:0] BIT_PERIOD_MAX_CYC = 14'(CLK_HZ / MIN_BIT_RATE_HZ);
    localparam logic [1:0] STRAP_SETTLE = 2'h2; // Cycles until strap sync holds the pin

    // Run state, one-hot
    typedef enum logic [2:0] {
        ST_STRAP = 3'b001,
        ST_RUN = 3'b010,
        ST_HOLD = 3'b100
    } run_state_e;

endpackage : cvsd_pkg

/* File: delta_rx_model.sv */
// Far-end receiver model: reads the word stream and reruns the coincidence rule
`timescale 1ns/10ps
`default_nettype none

module delta_rx_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic len4,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [1:0] out_data,
    output logic out_ready,
    output int words,
    output int faults
);
    logic [3:0] hist;
    logic same;
    initial out_ready = 1'b0;

    // Take a word at the rising edge where valid and ready meet
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            hist = cvsd_pkg::HIST_RST;
            words = 0;
            faults = 0;
        end else if (out_valid === 1'b1 && out_ready) begin
            hist = {hist[2:0], out_data[cvsd_pkg::FIFO_BIT_POS]};
            same = len4 ? (hist == 4'hf || hist == 4'h0) : (hist[2:0] == 3'h7 || hist[2:0] == 3'h0);
            if (same !== out_data[cvsd_pkg::FIFO_COINC_POS]) begin
                faults++;
            end
            words++;
        end
    end

    // Ready changes only between rising edges
    always @(negedge clk_sys) begin
        out_ready = rst_n && !stall;
    end
endmodule : delta_rx_model

`default_nettype wire

/* File: hist_shift.sv */
// History shift register with all-ones or all-zeros coincidence detection
`timescale 1ns/10ps
`default_nettype none

module hist_shift (
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    input wire logic shift_en,
    input wire logic bit_in,
    input wire logic len4,
    output logic [3:0] hist,
    output logic coinc
);

    typedef struct packed {
        logic [3:0] hist;
    } hist_state_s;

    hist_state_s state_ff;
    hist_state_s nxt_state;
    logic [3:0] shifted;

    ////////////////////////////////////////////////////////////////////////////
    // Newest bit enters at bit 0, oldest falls off the top
    assign shifted[0] = bit_in;
    generate
        for (genvar i = 1; i < cvsd_pkg::HIST_W; i++) begin : g_stage
            assign shifted[i] = state_ff.hist[i-1];
        end
    endgenerate

    // Next state
    always_comb begin
        nxt_state = state_ff;
        if (shift_en) begin
            nxt_state.hist = shifted;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_ff.hist <= cvsd_pkg::HIST_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Coincidence over three or four newest bits
    assign hist = state_ff.hist;
    always_comb begin
        if (len4) begin
            coinc = (&state_ff.hist) | ~(|state_ff.hist);
        end else begin
            coinc = (&state_ff.hist[2:0]) | ~(|state_ff.hist[2:0]);
        end
    end

endmodule : hist_shift

`default_nettype wire

/* File: slope_delta_coincidence_logic_tb_top.sv */
// Self-checking bench of the slope delta core with a far-end receiver model
`timescale 1ns/10ps
`default_nettype none

module slope_delta_coincidence_logic_tb_top;
    localparam logic [13:0] PER = 14'h0028;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic bit_clk = 1'b0;
    logic cmp_sign = 1'b0;
    logic rx_bit = 1'b0;
    logic dec_sel = 1'b0;
    logic len4_strap = 1'b0;
    logic stall = 1'b0;
    logic out_ready, dout, slope_up, coinc, idle_alt, rate_low, out_valid;
    logic [1:0] out_data;
    logic [3:0] hist_exp;
    int words, faults, w0;
    int mismatches = 0;
    int compares = 0;

    always #5 clk_sys = ~clk_sys;

    cvsd_core #(.BIT_PERIOD_MAX(PER)) dut (.clk_sys, .rst_n, .bit_clk, .cmp_sign, .rx_bit,
        .dec_sel, .len4_strap, .out_ready, .dout, .slope_up, .coinc, .idle_alt, .rate_low,
        .out_valid, .out_data);
    delta_rx_model far (.clk_sys, .rst_n, .len4(len4_strap), .stall, .out_valid, .out_data,
        .out_ready, .words, .faults);

    ////////////////////////////////////////////////////////////////////////////////
    // Compare, verdict and watchdog
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #200us;
        mismatches++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset with a strap value, one bit through the pins
    task automatic do_reset(input logic l4);
        @(negedge clk_sys);
        rst_n = 1'b0;
        len4_strap = l4;
        dec_sel = 1'b0;
        hist_exp = cvsd_pkg::HIST_RST;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (10) @(negedge clk_sys);
        check("idle_alt", 8'h01, idle_alt);
        check("coinc", 8'h00, coinc);
    endtask : do_reset

    task automatic send_bit(input logic b, input bit chk);
        logic s, a;
        @(negedge clk_sys);
        cmp_sign = b ^ dec_sel;
        rx_bit = b ^ !dec_sel;
        bit_clk = 1'b1;
        repeat (3) @(negedge clk_sys);
        bit_clk = 1'b0;
        repeat (5) @(negedge clk_sys);
        hist_exp = {hist_exp[2:0], b};
        s = len4_strap ? (hist_exp == 4'hf || hist_exp == 4'h0) : (hist_exp[2:0] == 3'h7 || hist_exp[2:0] == 3'h0);
        a = len4_strap ? (hist_exp == cvsd_pkg::ALT_A || hist_exp == cvsd_pkg::ALT_B)
            : (hist_exp[2:0] == cvsd_pkg::ALT3_A || hist_exp[2:0] == cvsd_pkg::ALT3_B);
        if (chk) begin
            check("dout", 8'(b), dout);
            check("slope_up", 8'(b), slope_up);
            check("coinc", 8'(s), coinc);
            check("idle_alt", 8'(a), idle_alt);
            check("rate_low", 8'h00, rate_low);
        end
    endtask : send_bit

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic sc_idle();
        for (int i = 0; i < 10; i++) begin
            send_bit(i[0], 1'b1);
        end
    endtask : sc_idle

    task automatic sc_runs();
        logic [9:0] pat = 10'h21e;
        w0 = words;
        for (int i = 0; i < 10; i++) begin
            send_bit(pat[i], 1'b1);
        end
        repeat (6) @(negedge clk_sys);
        check("words", 8'h0a, 8'(words - w0));
    endtask : sc_runs

    task automatic sc_decode();
        dec_sel = 1'b1;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < 6; i++) begin
            send_bit(i > 3, 1'b1);
        end
        dec_sel = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask : sc_decode

    task automatic sc_rate();
        repeat (int'(PER) + 20) @(negedge clk_sys);
        check("rate_low", 8'h01, rate_low);
    endtask : sc_rate

    task automatic sc_fill();
        int n = 0;
        stall = 1'b1;
        w0 = words;
        for (int i = 0; i < 18; i++) begin
            send_bit(1'b1, 1'b0);
        end
        check("out_valid", 8'h01, out_valid);
        stall = 1'b0;
        while (out_valid !== 1'b0 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 100) begin
            mismatches++;
            report_and_stop();
        end
        check("drained", 8'h01, 8'(words - w0 >= 16));
        check("coinc", 8'h01, coinc);
    endtask : sc_fill

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence, both history lengths
    initial begin
        do_reset(1'b0);
        sc_idle();
        sc_runs();
        sc_decode();
        sc_rate();
        check("rx_faults", 8'h00, 8'(faults));
        do_reset(1'b1);
        sc_idle();
        sc_runs();
        sc_decode();
        sc_fill();
        check("rx_faults", 8'h00, 8'(faults));
        report_and_stop();
    end
endmodule : slope_delta_coincidence_logic_tb_top

`default_nettype wire
